/* hbpc_pkg.sv */
`default_nettype none
package hbpc_pkg;
  // timebase
  localparam int CLK_PERIOD_NS   = 8;
  localparam int STANDBY_TIME_NS = 1000000;
  localparam int WAKE_TIME_NS    = 30000;
  localparam int OFF_TIME_NS     = 25000;
  localparam int DEAD_TIME_NS    = 50;
  // idle must exceed this, so enter after the full count
  localparam int STANDBY_CYC = STANDBY_TIME_NS / CLK_PERIOD_NS;
  // longest time, rounded down
  localparam int WAKE_CYC    = WAKE_TIME_NS / CLK_PERIOD_NS;
  localparam int OFF_CYC     = OFF_TIME_NS / CLK_PERIOD_NS;
  // least time, rounded up
  localparam int DEAD_CYC    = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W       = 17;
  localparam int DEAD_W      = 4;

  // switch pattern {hs_a, ls_a, hs_b, ls_b}
  localparam logic [3:0] PAT_OFF   = 4'h0;
  localparam logic [3:0] PAT_FWD   = 4'h9;
  localparam logic [3:0] PAT_REV   = 4'h6;
  localparam logic [3:0] PAT_BRAKE = 4'h5;

  // synchronised pin inputs
  localparam int IDX_A    = 0;
  localparam int IDX_B    = 1;
  localparam int IDX_TRIP = 2;
  localparam int IDX_ZERO = 3;
  localparam int IDX_OT   = 4;
  localparam int IDX_UV   = 5;
  localparam int IDX_OC   = 6;
  localparam int N_SYNC   = 7;
  localparam logic [N_SYNC-1:0] SYNC_RST = 7'h00;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_WAKE    = 3'b001,
    ST_RUN     = 3'b010,
    ST_FAST    = 3'b011,
    ST_SLOW    = 3'b100
  } hbpc_state_t;
endpackage
`default_nettype wire

/* hbpc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module hbpc_sync #(
  parameter int              W   = 1,
  parameter logic [W-1:0]    RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] nxt_s1;
  logic [W-1:0] nxt_s2;

  // first stage feeds only the second
  always_comb begin
    nxt_s1 = i_d;
    nxt_s2 = s1_ff;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      s1_ff <= RST;
      s2_ff <= RST;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

  assign o_q = s2_ff;
endmodule
`default_nettype wire

/* hbpc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module hbpc_core #(
  parameter int STANDBY_CYCLES = hbpc_pkg::STANDBY_CYC,
  parameter int WAKE_CYCLES    = hbpc_pkg::WAKE_CYC,
  parameter int OFF_CYCLES     = hbpc_pkg::OFF_CYC,
  parameter int DEAD_CYCLES    = hbpc_pkg::DEAD_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_ctrl_input_a,
  input  wire logic i_ctrl_input_b,
  input  wire logic i_current_trip,
  input  wire logic i_zero_current,
  input  wire logic i_over_temp,
  input  wire logic i_undervoltage,
  input  wire logic i_overcurrent,
  output logic      o_hs_a,
  output logic      o_ls_a,
  output logic      o_hs_b,
  output logic      o_ls_b,
  output logic      o_standby,
  output logic      o_charge_pump_en,
  output logic      o_regulator_en,
  output logic      o_protect_latched
);
  localparam int CW = hbpc_pkg::CNT_W;
  localparam int DW = hbpc_pkg::DEAD_W;
  localparam logic [CW-1:0] STBY_LAST = CW'(STANDBY_CYCLES - 1);
  localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYCLES - 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(OFF_CYCLES / 2 - 1);
  localparam logic [CW-1:0] OFF_LAST  = CW'(OFF_CYCLES - 1);
  localparam logic [DW-1:0] DEAD_LAST = DW'(DEAD_CYCLES - 1);

  logic [hbpc_pkg::N_SYNC-1:0] raw;
  logic [hbpc_pkg::N_SYNC-1:0] syn;
  logic a_s, b_s, trip_s, zero_s, ot_s, uv_s, oc_s;
  logic fault;
  logic off_phase;

  hbpc_pkg::hbpc_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          dir_fwd_ff, nxt_dir_fwd;
  logic          zero_seen_ff, nxt_zero_seen;
  logic          oc_lat_ff, nxt_oc_lat;
  logic          standby_ff, nxt_standby;
  logic          en_ff, nxt_en;
  logic [3:0]    want;
  logic [3:0]    out_ff, nxt_out;
  logic [DW-1:0] dead_cnt_ff, nxt_dead_cnt;
  logic          dead_rdy;

  // all pins cross into the timebase domain
  assign raw = {i_overcurrent, i_undervoltage, i_over_temp, i_zero_current,
                i_current_trip, i_ctrl_input_b, i_ctrl_input_a};

  hbpc_sync #(
    .W   (hbpc_pkg::N_SYNC),
    .RST (hbpc_pkg::SYNC_RST)
  ) u_sync (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_d     (raw),
    .o_q     (syn)
  );

  assign a_s    = syn[hbpc_pkg::IDX_A];
  assign b_s    = syn[hbpc_pkg::IDX_B];
  assign trip_s = syn[hbpc_pkg::IDX_TRIP];
  assign zero_s = syn[hbpc_pkg::IDX_ZERO];
  assign ot_s   = syn[hbpc_pkg::IDX_OT];
  assign uv_s   = syn[hbpc_pkg::IDX_UV];
  assign oc_s   = syn[hbpc_pkg::IDX_OC];

  // thermal hysteresis lives in the sensor, so the level is used as is
  assign fault     = ot_s | uv_s | oc_lat_ff;
  assign off_phase = (state_ff == hbpc_pkg::ST_FAST) || (state_ff == hbpc_pkg::ST_SLOW);

  // sequencer: standby, wake, run and the fixed off-time chopper
  always_comb begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff + CW'(1);
    nxt_dir_fwd   = dir_fwd_ff;
    nxt_zero_seen = zero_seen_ff | (off_phase & zero_s);
    nxt_oc_lat    = oc_lat_ff | oc_s; // only a reset clears it
    case (state_ff)
      hbpc_pkg::ST_STANDBY: begin
        nxt_cnt = '0;
        if (a_s || b_s) begin
          nxt_state = hbpc_pkg::ST_WAKE;
        end
      end
      hbpc_pkg::ST_WAKE: begin
        // pump settles before the bridge may switch
        if (cnt_ff == WAKE_LAST) begin
          nxt_state = hbpc_pkg::ST_RUN;
          nxt_cnt   = '0;
        end
      end
      hbpc_pkg::ST_RUN: begin
        if (a_s ^ b_s) begin
          nxt_cnt = '0;
          if (trip_s) begin
            nxt_state     = hbpc_pkg::ST_FAST;
            nxt_dir_fwd   = a_s;
            nxt_zero_seen = 1'b0;
          end
        end else if (a_s || b_s) begin
          nxt_cnt = '0;
        end else if (cnt_ff == STBY_LAST) begin
          nxt_state = hbpc_pkg::ST_STANDBY;
          nxt_cnt   = '0;
        end
      end
      hbpc_pkg::ST_FAST: begin
        if (cnt_ff == HALF_LAST) begin
          nxt_state = hbpc_pkg::ST_SLOW;
        end
      end
      hbpc_pkg::ST_SLOW: begin
        if (cnt_ff == OFF_LAST) begin
          nxt_state = hbpc_pkg::ST_RUN;
          nxt_cnt   = '0;
        end
      end
      default: begin
        nxt_state = hbpc_pkg::ST_STANDBY;
        nxt_cnt   = '0;
      end
    endcase
    nxt_standby = (nxt_state == hbpc_pkg::ST_STANDBY);
    nxt_en      = !nxt_standby;
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff     <= hbpc_pkg::ST_STANDBY;
      cnt_ff       <= '0;
      dir_fwd_ff   <= 1'b1;
      zero_seen_ff <= 1'b0;
      oc_lat_ff    <= 1'b0;
      standby_ff   <= 1'b1;
      en_ff        <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      dir_fwd_ff   <= nxt_dir_fwd;
      zero_seen_ff <= nxt_zero_seen;
      oc_lat_ff    <= nxt_oc_lat;
      standby_ff   <= nxt_standby;
      en_ff        <= nxt_en;
    end
  end

  // wanted switch pattern; protection overrides everything
  always_comb begin
    want = hbpc_pkg::PAT_OFF;
    if (fault) begin
      want = hbpc_pkg::PAT_OFF;
    end else begin
      case (state_ff)
        hbpc_pkg::ST_RUN: begin
          if (a_s && !b_s) begin
            want = hbpc_pkg::PAT_FWD;
          end else if (!a_s && b_s) begin
            want = hbpc_pkg::PAT_REV;
          end else if (a_s && b_s) begin
            want = hbpc_pkg::PAT_BRAKE;
          end else begin
            want = hbpc_pkg::PAT_OFF;
          end
        end
        hbpc_pkg::ST_FAST: begin
          // reversed pair conducts the decaying current
          if (!zero_seen_ff) begin
            want = dir_fwd_ff ? hbpc_pkg::PAT_REV : hbpc_pkg::PAT_FWD;
          end
        end
        hbpc_pkg::ST_SLOW: begin
          if (!zero_seen_ff) begin
            want = hbpc_pkg::PAT_BRAKE;
          end
        end
        default: begin
          want = hbpc_pkg::PAT_OFF;
        end
      endcase
    end
  end

  // output stage: any change of on-pattern passes through all-off for the dead time
  assign dead_rdy = (dead_cnt_ff == DEAD_LAST);
  always_comb begin
    nxt_out      = out_ff;
    nxt_dead_cnt = '0;
    if (out_ff == hbpc_pkg::PAT_OFF) begin
      nxt_dead_cnt = dead_rdy ? dead_cnt_ff : dead_cnt_ff + DW'(1);
    end
    if (want != out_ff) begin
      if (out_ff != hbpc_pkg::PAT_OFF) begin
        nxt_out = hbpc_pkg::PAT_OFF;
      end else if (dead_rdy) begin
        nxt_out = want;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      out_ff      <= hbpc_pkg::PAT_OFF;
      dead_cnt_ff <= '0;
    end else begin
      out_ff      <= nxt_out;
      dead_cnt_ff <= nxt_dead_cnt;
    end
  end

  assign o_hs_a            = out_ff[3];
  assign o_ls_a            = out_ff[2];
  assign o_hs_b            = out_ff[1];
  assign o_ls_b            = out_ff[0];
  assign o_standby         = standby_ff;
  assign o_charge_pump_en  = en_ff;
  assign o_regulator_en    = en_ff;
  assign o_protect_latched = oc_lat_ff;

  property p_drive_dir;
    @(posedge i_clk) disable iff (i_reset)
    (state_ff == hbpc_pkg::ST_RUN && !fault && (a_s ^ b_s) && out_ff == hbpc_pkg::PAT_OFF && dead_rdy)
    |=> out_ff == ($past(a_s) ? hbpc_pkg::PAT_FWD : hbpc_pkg::PAT_REV);
  endproperty
  a_drive_dir: assert property (p_drive_dir) else $error("drive pattern does not follow inputs");

  property p_brake;
    @(posedge i_clk) disable iff (i_reset)
    (state_ff == hbpc_pkg::ST_RUN && !fault && a_s && b_s)[*2]
    |-> (out_ff == hbpc_pkg::PAT_OFF || out_ff == hbpc_pkg::PAT_BRAKE);
  endproperty
  a_brake: assert property (p_brake) else $error("brake not on low sides");

  property p_idle;
    @(posedge i_clk) disable iff (i_reset)
    (state_ff == hbpc_pkg::ST_RUN && !a_s && !b_s && cnt_ff == STBY_LAST)
    |=> state_ff == hbpc_pkg::ST_STANDBY && o_standby && out_ff == hbpc_pkg::PAT_OFF;
  endproperty
  a_idle: assert property (p_idle) else $error("idle did not enter standby");

  property p_standby;
    @(posedge i_clk) disable iff (i_reset)
    state_ff == hbpc_pkg::ST_STANDBY |-> !o_charge_pump_en && !o_regulator_en && o_standby;
  endproperty
  a_standby: assert property (p_standby) else $error("standby left enables on");

  property p_wake;
    @(posedge i_clk) disable iff (i_reset)
    state_ff == hbpc_pkg::ST_WAKE |-> cnt_ff <= WAKE_LAST && out_ff == hbpc_pkg::PAT_OFF && o_charge_pump_en;
  endproperty
  a_wake: assert property (p_wake) else $error("wake delay overrun or bridge active");

  property p_trip;
    @(posedge i_clk) disable iff (i_reset)
    (state_ff == hbpc_pkg::ST_RUN && (a_s ^ b_s) && trip_s) |=> state_ff == hbpc_pkg::ST_FAST && cnt_ff == '0;
  endproperty
  a_trip: assert property (p_trip) else $error("trip did not start off phase");

  property p_off_time;
    @(posedge i_clk) disable iff (i_reset)
    (state_ff == hbpc_pkg::ST_FAST && cnt_ff == HALF_LAST)
    |=> state_ff == hbpc_pkg::ST_SLOW && cnt_ff == HALF_LAST + CW'(1);
  endproperty
  a_off_time: assert property (p_off_time) else $error("fast half wrong length");

  // counter-based so the long off time needs no huge delay
  property p_off_end;
    @(posedge i_clk) disable iff (i_reset)
    (state_ff == hbpc_pkg::ST_SLOW && cnt_ff == OFF_LAST) |=> state_ff == hbpc_pkg::ST_RUN;
  endproperty
  a_off_end: assert property (p_off_end) else $error("off phase did not end on time");

  property p_no_direct;
    @(posedge i_clk) disable iff (i_reset)
    ($past(out_ff) != hbpc_pkg::PAT_OFF && out_ff != hbpc_pkg::PAT_OFF) |-> out_ff == $past(out_ff);
  endproperty
  a_no_direct: assert property (p_no_direct) else $error("pattern changed without dead time");

  property p_zero_cut;
    @(posedge i_clk) disable iff (i_reset)
    (off_phase && zero_seen_ff)[*2] |-> out_ff == hbpc_pkg::PAT_OFF;
  endproperty
  a_zero_cut: assert property (p_zero_cut) else $error("rectifier on after zero current");

  property p_fault_off;
    @(posedge i_clk) disable iff (i_reset)
    fault |=> out_ff == hbpc_pkg::PAT_OFF;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("bridge on under protection");

  property p_oc_latch;
    @(posedge i_clk) disable iff (i_reset)
    oc_s |=> o_protect_latched [*3];
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("overcurrent not latched");
endmodule
`default_nettype wire

/* hbpc_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hbpc_ctrl_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_pwm,
  output logic            o_ctrl_input_a,
  output logic            o_ctrl_input_b
);
  logic [3:0] phase = 4'h0;
  logic       on;
  // 16-cycle pwm period, low half kept short of the standby timeout
  always @(negedge i_clk) begin
    phase <= phase + 4'h1;
  end
  // mode 0 idle, 1 forward, 2 reverse, 3 brake
  always_comb begin
    on = !i_pwm || !phase[3];
    o_ctrl_input_a = (i_mode == 2'h1) ? on : (i_mode == 2'h3);
    o_ctrl_input_b = (i_mode == 2'h2) ? on : (i_mode == 2'h3);
  end
endmodule
`default_nettype wire

/* hbpc_core_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module hbpc_core_tb;
  localparam int STB = 50;
  localparam int WAKE = 10;
  localparam int OFF = 40;
  localparam int DEAD = hbpc_pkg::DEAD_CYC;
  logic clk = 1'b0, rst = 1'b1, trip = 1'b0, zero = 1'b0, ot = 1'b0, uv = 1'b0, oc = 1'b0;
  logic pwm = 1'b0;
  logic [1:0] mode = 2'h0;
  logic a, b, hs_a, ls_a, hs_b, ls_b, stby, cp_en, rg_en, latched;
  logic [3:0] pat;
  int miscompares = 0, n_tests = 0, cycles = 0, n_runs;
  logic [3:0] run_pat [8];
  int run_len [8];
  assign pat = {hs_a, ls_a, hs_b, ls_b};

  hbpc_ctrl_model i_ctrl (.i_clk(clk), .i_mode(mode), .i_pwm(pwm), .o_ctrl_input_a(a), .o_ctrl_input_b(b));
  hbpc_core #(.STANDBY_CYCLES(STB), .WAKE_CYCLES(WAKE), .OFF_CYCLES(OFF), .DEAD_CYCLES(DEAD)) i_dut (
    .i_clk(clk), .i_reset(rst), .i_ctrl_input_a(a), .i_ctrl_input_b(b), .i_current_trip(trip),
    .i_zero_current(zero), .i_over_temp(ot), .i_undervoltage(uv), .i_overcurrent(oc),
    .o_hs_a(hs_a), .o_ls_a(ls_a), .o_hs_b(hs_b), .o_ls_b(ls_b), .o_standby(stby),
    .o_charge_pump_en(cp_en), .o_regulator_en(rg_en), .o_protect_latched(latched));

  initial begin
    forever #4 clk = ~clk;
  end
  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check({pat, stby, cp_en, rg_en, latched}, 16'h0008);
  endtask
  task automatic wait_pat(input logic [3:0] exp, input int lim);
    int k;
    k = 0;
    while (pat !== exp && k < lim) begin
      @(negedge clk);
      k++;
    end
    check(pat, exp);
  endtask
  // run-length record of the switch pattern, shoot-through checked each cycle
  task automatic watch(input int n);
    n_runs = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      check((hs_a & ls_a) | (hs_b & ls_b), 1'b0);
      if (n_runs > 0 && run_pat[n_runs-1] === pat) run_len[n_runs-1]++;
      else if (n_runs < 8) begin
        run_pat[n_runs] = pat;
        run_len[n_runs] = 1;
        n_runs++;
      end
    end
  endtask
  task automatic t_wake();
    int c;
    c = 0;
    mode = 2'h1;
    while (stby === 1'b1 && c < 10) begin
      @(negedge clk);
      c++;
    end
    check({stby, cp_en, rg_en}, 3'h3);
    c = 0;
    while (pat === 4'h0 && c < 100) begin
      @(negedge clk);
      c++;
    end
    check(c >= WAKE && c <= WAKE + DEAD + 2, 1'b1);
    check(pat, hbpc_pkg::PAT_FWD);
  endtask
  task automatic t_drive();
    mode = 2'h2;
    wait_pat(hbpc_pkg::PAT_REV, 20);
    mode = 2'h3;
    wait_pat(hbpc_pkg::PAT_BRAKE, 20);
    mode = 2'h1;
    wait_pat(hbpc_pkg::PAT_FWD, 20);
  endtask
  // fast decay lights the opposite diagonal, slow decay both low sides
  task automatic t_trip(input logic [1:0] m, input logic [3:0] drv, input logic [3:0] fast);
    mode = m;
    wait_pat(drv, 20);
    trip = 1'b1;
    @(negedge clk);
    trip = 1'b0;
    watch(OFF + 20);
    check(n_runs, 7);
    check({run_pat[1], run_pat[2], run_pat[3]}, {4'h0, fast, 4'h0});
    check({run_pat[4], run_pat[6]}, {hbpc_pkg::PAT_BRAKE, drv});
    check(run_len[1] >= DEAD && run_len[3] >= DEAD, 1'b1);
    check(run_len[1] + run_len[2] - run_len[3] - run_len[4] + 1 <= 2, 1'b1);
    check(run_len[1] + run_len[2] + run_len[3] + run_len[4] - OFF + 1 <= 3, 1'b1);
  endtask
  task automatic t_zero();
    trip = 1'b1;
    @(negedge clk);
    trip = 1'b0;
    repeat (3) @(negedge clk);
    zero = 1'b1;
    watch(OFF + 20);
    zero = 1'b0;
    check({run_pat[0], run_pat[1]}, {4'h0, hbpc_pkg::PAT_FWD});
    check(run_len[0] >= OFF - 2, 1'b1);
  endtask
  task automatic t_fault();
    for (int f = 0; f < 2; f++) begin
      ot = (f == 0);
      uv = (f == 1);
      wait_pat(4'h0, 6);
      repeat (20) @(negedge clk);
      check(pat, 4'h0);
      ot = 1'b0;
      uv = 1'b0;
      wait_pat(hbpc_pkg::PAT_FWD, 20);
    end
  endtask
  task automatic t_standby();
    int c, k;
    c = 0;
    k = 0;
    mode = 2'h0;
    // idle is timed from the pin change, so standby must come strictly later
    while (stby === 1'b0 && c < STB + 20) begin
      @(negedge clk);
      c++;
      if (k == 0 && pat === 4'h0) k = c;
    end
    check(k > 0 && k <= 12, 1'b1);
    check(c > STB && c <= STB + 4, 1'b1);
    check({stby, cp_en, rg_en}, 3'h4);
    pwm = 1'b1;
    mode = 2'h1;
    wait_pat(hbpc_pkg::PAT_FWD, WAKE + 40);
    c = 0;
    for (int i = 0; i < 3 * STB; i++) begin
      @(negedge clk);
      if (stby !== 1'b0) c++;
    end
    check(c, 0);
    pwm = 1'b0;
  endtask
  task automatic t_overcurrent();
    oc = 1'b1;
    @(negedge clk);
    oc = 1'b0;
    wait_pat(4'h0, 6);
    repeat (30) @(negedge clk);
    check({latched, pat}, 5'h10);
    do_reset();
  endtask

  // inputs move on the falling edge only
  initial begin
    @(negedge clk);
    do_reset();
    t_wake();
    t_drive();
    t_trip(2'h1, hbpc_pkg::PAT_FWD, hbpc_pkg::PAT_REV);
    t_trip(2'h2, hbpc_pkg::PAT_REV, hbpc_pkg::PAT_FWD);
    mode = 2'h1;
    wait_pat(hbpc_pkg::PAT_FWD, 20);
    t_zero();
    t_fault();
    t_standby();
    t_overcurrent();
    close_out();
  end
endmodule
`default_nettype wire
